// ===== include/smbus_flag_map.vh
// register offsets, field positions, reset values and timing counts for the smbus flag block
`ifndef SMBUS_FLAG_MAP_VH
`define SMBUS_FLAG_MAP_VH

// register offsets on the plain register port
`define REG_CONTROL      3'h0
`define REG_DATA         3'h1
`define REG_INT_STATUS   3'h2
`define REG_INT_CLEAR    3'h3
`define REG_INT_ENABLE   3'h4

// bus_control_register field positions
`define CTL_SI           0
`define CTL_ACK          1
`define CTL_ARB_LOST     2
`define CTL_ACK_REQ      3
`define CTL_STOP         4
`define CTL_START        5
`define CTL_TX_MODE      6
`define CTL_MASTER       7

// interrupt status field positions
`define INT_SI_SET       0
`define INT_ARB_LOST     1
`define INT_STOP_SEEN    2
`define INT_ADDRESSED    3

// reset values
`define CONTROL_RESET    8'h00
`define DATA_RESET       8'h00
`define INT_RESET        4'h0

// timing
`define CLK_PERIOD_NS    20
`define SCL_HALF_NS      5000
`define SCL_HALF_CYCLES  (`SCL_HALF_NS / `CLK_PERIOD_NS)
`define SCL_HALF_LAST    9'h0f9
`define BYTE_ACK_SLOT    4'h8

`endif

// ===== design/smbus_control_flag_update.v
// smbus control flag update logic with bus condition tracking and a small master sequencer
`timescale 1ns/1ps
`include "smbus_flag_map.vh"

module smbus_control_flag_update (
   // clock and reset
   input  wire       clk,
   input  wire       rst_n,
   // register port
   input  wire [2:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr,
   input  wire       rd,
   output reg  [7:0] rdata,
   // open-drain bus pins
   input  wire       scl_in,
   output wire       scl_out,
   output reg        scl_oe_n,
   input  wire       sda_in,
   output wire       sda_out,
   output reg        sda_oe_n,
   // interrupt
   output wire       irq
);

   localparam M_IDLE  = 3'd0;
   localparam M_START = 3'd1;
   localparam M_LOW   = 3'd2;
   localparam M_HIGH  = 3'd3;
   localparam M_STOP1 = 3'd4;
   localparam M_STOP2 = 3'd5;
   localparam M_STOP3 = 3'd6;
   localparam M_RS1   = 3'd7;

   // last count of a half period, sized to the counter so the compare is exact
   localparam [8:0] HALF_LAST = `SCL_HALF_LAST;

   // bit that goes out in the given slot, msb first
   function tx_bit;
      input [7:0] data;
      input [3:0] slot;
      begin
         tx_bit = data[3'd7 - slot[2:0]];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   wire [1:0] pins_in = {scl_in, sda_in};
   reg  [1:0] pins_meta;
   reg  [1:0] pins_sync;
   reg  [1:0] pins_prev;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : sync
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               pins_meta[g] <= 1'b1;
               pins_sync[g] <= 1'b1;
               pins_prev[g] <= 1'b1;
            end else begin
               pins_meta[g] <= pins_in[g];
               pins_sync[g] <= pins_meta[g];
               pins_prev[g] <= pins_sync[g];
            end
         end
      end
   endgenerate

   wire scl_s = pins_sync[1];
   wire sda_s = pins_sync[0];
   wire scl_p = pins_prev[1];
   wire sda_p = pins_prev[0];

   wire scl_rise  = scl_s & ~scl_p;
   wire scl_fall  = ~scl_s & scl_p;
   wire start_det = scl_s & scl_p & sda_p & ~sda_s;
   wire stop_det  = scl_s & scl_p & ~sda_p & sda_s;

   ////////////////////////////////////////////////////////////////////////////
   // state
   reg       master;
   reg       tx_mode;
   reg       start_flag;
   reg       stop_flag;
   reg       ack_request_flag;
   reg       arbitration_lost_flag;
   reg       ack_flag;
   reg       si;
   reg [7:0] bus_data_register;
   reg       data_written;
   reg [7:0] rx_shift;
   reg [3:0] bit_cnt;
   reg       first_byte;
   reg       byte_done;
   reg       busy;
   reg       addressed;
   reg [2:0] mstate;
   reg [2:0] next_mstate;
   reg [8:0] cnt;
   // restart high phase: both lines released before the new start
   reg       rs_high;
   reg [3:0] int_status;
   reg [3:0] int_enable;

   wire half_tick = (cnt == HALF_LAST);
   wire own_cond  = (mstate == M_START) | (mstate == M_STOP3);
   wire ext_start = start_det & ~own_cond;
   wire ext_stop  = stop_det & ~own_cond;

   wire sw_ctl_wr = wr & (addr == `REG_CONTROL);
   wire sw_si_clr = sw_ctl_wr & ~wdata[`CTL_SI] & si;

   // events
   wire ev_start_gen = (mstate == M_START) & half_tick;
   wire ev_stop_gen  = (mstate == M_STOP3) & half_tick;
   wire arb_rs       = ext_start & master & ~start_flag;
   wire arb_scl      = (mstate == M_STOP2) & half_tick & ~scl_s;
   wire arb_rs_scl   = rs_high & half_tick & ~scl_s;
   // only data high phases count: a stop or restart pulls sda low on purpose
   wire arb_sda      = scl_rise & master & tx_mode & (mstate == M_HIGH) &
                       (bit_cnt < `BYTE_ACK_SLOT) &
                       tx_bit(bus_data_register, bit_cnt) & ~sda_s;
   wire arb_stop     = ext_stop & master;
   wire ev_arb       = arb_rs | arb_scl | arb_rs_scl | arb_sda | arb_stop;
   wire ev_rx_byte   = scl_fall & busy & (bit_cnt == `BYTE_ACK_SLOT) & ~tx_mode;
   wire ev_tx_byte   = scl_fall & byte_done;
   wire ev_addr      = ev_rx_byte & first_byte & ~master;
   wire ev_slv_stop  = ext_stop & addressed & ~master;
   wire si_set       = ev_start_gen | ev_arb | ev_rx_byte | ev_tx_byte | ev_slv_stop;

   ////////////////////////////////////////////////////////////////////////////
   // master sequencer
   always @* begin
      next_mstate = mstate;
      case (mstate)
         M_IDLE: begin
            // a restart keeps the bus busy, so it leaves idle on its own timer
            if (rs_high) begin
               if (half_tick)
                  next_mstate = M_START;
            end else if (start_flag && !busy && !master) begin
               next_mstate = M_START;
            end
         end
         M_START: if (half_tick) next_mstate = M_LOW;
         M_LOW: begin
            // scl stays low while software owns the interrupt flag
            if (half_tick && !si) begin
               if (bit_cnt == 4'h0 && !first_byte && stop_flag)
                  next_mstate = M_STOP1;
               else if (bit_cnt == 4'h0 && !first_byte && start_flag)
                  next_mstate = M_RS1;
               else
                  next_mstate = M_HIGH;
            end
         end
         M_HIGH:  if (half_tick) next_mstate = M_LOW;
         M_STOP1: if (half_tick) next_mstate = M_STOP2;
         M_STOP2: if (half_tick) next_mstate = scl_s ? M_STOP3 : M_IDLE;
         M_STOP3: if (half_tick) next_mstate = M_IDLE;
         M_RS1:   if (half_tick) next_mstate = M_IDLE;
         default: next_mstate = M_IDLE;
      endcase
      if (ev_arb)
         next_mstate = M_IDLE;
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mstate  <= M_IDLE;
         cnt     <= 9'h000;
         rs_high <= 1'b0;
      end else begin
         mstate <= next_mstate;
         // the M_HIGH phase only counts while scl is really high, which honours stretching
         if (next_mstate != mstate || (rs_high && half_tick))
            cnt <= 9'h000;
         else if (!half_tick && (mstate != M_HIGH || scl_s))
            cnt <= cnt + 9'h001;
         if (mstate == M_RS1 && half_tick && !ev_arb)
            rs_high <= 1'b1;
         else if (rs_high && half_tick)
            rs_high <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit tracking, shared by master and slave roles
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt    <= 4'h0;
         rx_shift   <= 8'h00;
         first_byte <= 1'b0;
         byte_done  <= 1'b0;
         busy       <= 1'b0;
         addressed  <= 1'b0;
      end else begin
         if (start_det) begin
            bit_cnt    <= 4'h0;
            first_byte <= 1'b1;
            byte_done  <= 1'b0;
            busy       <= 1'b1;
         end else if (stop_det) begin
            busy <= 1'b0;
         end else if (scl_rise && busy) begin
            if (bit_cnt == `BYTE_ACK_SLOT) begin
               bit_cnt    <= 4'h0;
               first_byte <= 1'b0;
               byte_done  <= tx_mode;
            end else begin
               bit_cnt  <= bit_cnt + 4'h1;
               rx_shift <= {rx_shift[6:0], sda_s};
            end
         end else if (scl_fall) begin
            byte_done <= 1'b0;
         end
         if (stop_det || ext_start || master)
            addressed <= 1'b0;
         else if (ev_addr)
            addressed <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control flags: software first, hardware clears, hardware sets last so sets win, except arbitration loss, which clears master and tx_mode after the sets
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         master                <= 1'b0;
         tx_mode               <= 1'b0;
         start_flag            <= 1'b0;
         stop_flag             <= 1'b0;
         ack_request_flag      <= 1'b0;
         arbitration_lost_flag <= 1'b0;
         ack_flag              <= 1'b0;
         si                    <= 1'b0;
         bus_data_register     <= `DATA_RESET;
         data_written          <= 1'b0;
      end else begin
         if (sw_ctl_wr) begin
            start_flag <= wdata[`CTL_START];
            stop_flag  <= wdata[`CTL_STOP];
            ack_flag   <= wdata[`CTL_ACK];
            si         <= wdata[`CTL_SI];
         end
         // a start opens a new frame, so a load left from an earlier frame is stale
         if (start_det)
            data_written <= 1'b0;
         if (wr && addr == `REG_DATA) begin
            bus_data_register <= wdata;
            data_written      <= 1'b1;
         end
         if (sw_si_clr)
            arbitration_lost_flag <= 1'b0;
         // slave or later master byte: direction follows whether data was loaded
         if (scl_fall && busy && bit_cnt == 4'h0 && !first_byte) begin
            tx_mode      <= data_written;
            data_written <= 1'b0;
         end
         if (ext_start)
            tx_mode <= 1'b0;
         if (scl_rise && busy && bit_cnt == `BYTE_ACK_SLOT) begin
            ack_request_flag <= 1'b0;
            if (tx_mode)
               ack_flag <= ~sda_s;
         end
         if (ev_stop_gen) begin
            master    <= 1'b0;
            stop_flag <= 1'b0;
         end
         if (ev_start_gen) begin
            master       <= 1'b1;
            tx_mode      <= 1'b1;
            data_written <= 1'b0;
         end
         if (ev_rx_byte) begin
            ack_request_flag  <= 1'b1;
            bus_data_register <= rx_shift;
         end
         if (ev_addr)
            start_flag <= 1'b1;
         if (ev_slv_stop || arb_stop)
            stop_flag <= 1'b1;
         if (ev_arb) begin
            arbitration_lost_flag <= 1'b1;
            master                <= 1'b0;
            tx_mode               <= 1'b0;
         end
         if (si_set)
            si <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive
   wire stretch = si & busy & ~master;
   wire scl_low = (mstate == M_LOW) | (mstate == M_STOP1) | (mstate == M_RS1) | stretch;
   wire ctl_phase = (mstate == M_START) | (mstate == M_STOP1) | (mstate == M_STOP2) |
                    (mstate == M_STOP3) | (mstate == M_RS1) | rs_high;
   wire ctl_low   = (mstate == M_START) | (mstate == M_STOP1) | (mstate == M_STOP2);
   // receiver pulls the ack slot low when software asked for an ack
   wire data_low  = busy & ((bit_cnt == `BYTE_ACK_SLOT) ? (~tx_mode & ack_flag) :
                            (tx_mode & ~tx_bit(bus_data_register, bit_cnt)));
   // data only moves while scl is seen low, so a bit never changes under a high clock
   wire next_sda_low = ctl_phase ? ctl_low : (scl_s ? ~sda_oe_n : data_low);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
      end else begin
         scl_oe_n <= ~scl_low;
         sda_oe_n <= ~next_sda_low;
      end
   end

   assign scl_out = 1'b0;
   assign sda_out = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status, enable and clear
   wire [3:0] int_events = {ev_addr, ev_slv_stop | arb_stop, ev_arb, si_set};
   wire       int_clr_wr = wr & (addr == `REG_INT_CLEAR);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_status <= `INT_RESET;
         int_enable <= `INT_RESET;
      end else begin
         int_status <= (int_status & ~(int_clr_wr ? wdata[3:0] : 4'h0)) | int_events;
         if (wr && addr == `REG_INT_ENABLE)
            int_enable <= wdata[3:0];
      end
   end

   assign irq = |(int_status & int_enable);

   ////////////////////////////////////////////////////////////////////////////
   // register reads, one cycle after the strobe
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            `REG_CONTROL:    rdata <= {master, tx_mode, start_flag, stop_flag,
                                       ack_request_flag, arbitration_lost_flag,
                                       ack_flag, si};
            `REG_DATA:       rdata <= bus_data_register;
            `REG_INT_STATUS: rdata <= {4'h0, int_status};
            `REG_INT_ENABLE: rdata <= {4'h0, int_enable};
            default:         rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

endmodule // smbus_control_flag_update

// ===== testbench/smbus_flag_checker.sv
// port-level assertions for the smbus flag block
`timescale 1ns/1ps
`include "smbus_flag_map.vh"

module smbus_flag_checker (
   // clock and reset
   input wire       clk,
   input wire       rst_n,
   // register port
   input wire [2:0] addr,
   input wire [7:0] wdata,
   input wire       wr,
   input wire       rd,
   input wire [7:0] rdata,
   // bus pins and interrupt
   input wire       scl_out,
   input wire       scl_oe_n,
   input wire       sda_out,
   input wire       sda_oe_n,
   input wire       irq
);
   reg ctl_ans;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////////
   // high in the cycle that carries a control read answer
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_ans <= 1'b0;
      end else begin
         ctl_ans <= rd && (addr == `REG_CONTROL);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   read_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data not zero outside an answer");
   reset_quiet_a: assert property ($rose(rst_n) |-> rdata == 8'h00 && !irq && scl_oe_n && sda_oe_n)
      else $error("outputs not idle after reset");
   master_arb_a: assert property (ctl_ans |-> !(rdata[`CTL_MASTER] && rdata[`CTL_ARB_LOST]))
      else $error("master still set with arbitration lost");
   arb_tx_a: assert property (ctl_ans && rdata[`CTL_ARB_LOST] |-> !rdata[`CTL_TX_MODE])
      else $error("transmit mode kept after arbitration loss");
   arb_si_a: assert property (ctl_ans && rdata[`CTL_ARB_LOST] |-> rdata[`CTL_SI])
      else $error("arbitration lost without interrupt flag");
   ack_req_rx_a: assert property (ctl_ans && rdata[`CTL_ACK_REQ] |-> !rdata[`CTL_TX_MODE])
      else $error("ack request outside a received byte");
   // a one cycle gap after each write, so the read follows two edges later
   start_hold_a: assert property ((wr && addr == `REG_CONTROL && wdata[`CTL_START]) ##1
      !(wr && addr == `REG_CONTROL) ##1 (rd && addr == `REG_CONTROL) |=> rdata[`CTL_START])
      else $error("start flag lost without software");
   arb_clear_a: assert property ((wr && addr == `REG_CONTROL && !wdata[`CTL_SI]) ##1
      !(wr && addr == `REG_CONTROL) ##1 (rd && addr == `REG_CONTROL) |=> !rdata[`CTL_ARB_LOST])
      else $error("arbitration lost kept after interrupt clear");
   drive_low_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
      else $error("open drain pin driven high");
   irq_mask_a: assert property ($past(wr) && $past(addr) == `REG_INT_ENABLE && $past(wdata) == 8'h00 |-> !irq)
      else $error("interrupt high while all masked");
endmodule // smbus_flag_checker

bind smbus_control_flag_update smbus_flag_checker i_checker (
   .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));

// ===== testbench/smbus_far_end.sv
// behavioural far-side device: acking slave, sda jammer and a simple master
`timescale 1ns/1ps

module smbus_far_end (
   // resolved bus lines
   input  wire scl,
   input  wire sda,
   // pull sda low while set
   input  wire jam,
   // open-drain drives, low pulls the line
   output wire scl_drv_n,
   output wire sda_drv_n
);
   reg       scl_m    = 1'b1;
   reg       sda_m    = 1'b1;
   reg       sda_s    = 1'b1;
   reg       mst      = 1'b0;
   reg       busy     = 1'b0;
   reg       ack_seen = 1'b1;
   reg [7:0] rx       = 8'h00;
   integer   bits     = 0;

   assign scl_drv_n = scl_m;
   assign sda_drv_n = sda_m & sda_s & ~jam;

   ////////////////////////////////////////////////////////////////////////////////
   // slave side: start and stop are sda edges while scl high
   always @(negedge sda) if (scl === 1'b1) begin
      busy = 1'b1;
      bits = -1;
   end
   always @(posedge sda) if (scl === 1'b1) busy = 1'b0;
   always @(posedge scl) if (busy && !mst && bits < 8) rx = {rx[6:0], sda};
   always @(negedge scl) if (busy && !mst) begin
      bits = bits + 1;
      sda_s = (bits == 8) ? 1'b0 : 1'b1;
      if (bits == 9) bits = 0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // master side, 160 ns link clock, stands still between frames
   task send_byte(input [7:0] b);
      integer i;
      mst = 1'b1;
      sda_m = 1'b0;
      #80 scl_m = 1'b0;
      for (i = 7; i >= 0; i = i - 1) begin
         #40 sda_m = b[i];
         #40 scl_m = 1'b1;
         #80 scl_m = 1'b0;
      end
   endtask

   // the device may stretch the ack clock, so wait for scl to really rise
   task ack_stop;
      integer n;
      #40 sda_m = 1'b1;
      #40 scl_m = 1'b1;
      for (n = 0; n < 50000 && scl !== 1'b1; n = n + 1) #20;
      #40 ack_seen = sda;
      #40 scl_m = 1'b0;
      #40 sda_m = 1'b0;
      #40 scl_m = 1'b1;
      #80 sda_m = 1'b1;
      mst = 1'b0;
   endtask
endmodule // smbus_far_end

// ===== testbench/smbus_control_flag_update_test.sv
// self-checking bench for the smbus flag block
`timescale 1ns/1ps
`include "smbus_flag_map.vh"

module smbus_control_flag_update_test;
   reg        clk         = 1'b0;
   reg        rst_n       = 1'b0;
   reg  [2:0] addr        = 3'h0;
   reg  [7:0] wdata       = 8'h00;
   reg        wr          = 1'b0;
   reg        rd          = 1'b0;
   reg        jam         = 1'b0;
   reg  [7:0] got         = 8'h00;
   reg  [7:0] b;
   reg  [7:0] sent_q[$];
   integer    mismatches  = 0;
   integer    comparisons = 0;
   integer    n;
   wire [7:0] rdata;
   wire       scl_oe_n, sda_oe_n, scl_drv_n, sda_drv_n, irq;
   wire       scl = scl_oe_n & scl_drv_n;
   wire       sda = sda_oe_n & sda_drv_n;

   initial begin
      forever #10 clk = ~clk;
   end

   smbus_control_flag_update i_dut (
      .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .scl_in(scl), .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n),
      .irq(irq));
   smbus_far_end i_far (
      .scl(scl), .sda(sda), .jam(jam), .scl_drv_n(scl_drv_n), .sda_drv_n(sda_drv_n));

   ////////////////////////////////////////////////////////////////////////////////
   task finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task chk(input [7:0] g, input [7:0] e);
      comparisons = comparisons + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // one gap cycle after each access keeps strobes from being assigned twice at an edge
   task wreg(input [2:0] a, input [7:0] d);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task rreg(input [2:0] a);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      got = rdata;
      @(posedge clk);
   endtask

   task rchk(input [2:0] a, input [7:0] e);
      rreg(a);
      chk(got, e);
   endtask

   task wait_irq;
      @(posedge clk);
      for (n = 0; n < 20000 && irq !== 1'b1; n = n + 1) @(posedge clk);
      if (irq !== 1'b1) begin
         mismatches = mismatches + 1;
         $display("unexpected at %0t: interrupt never came", $time);
         finish_test;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h0000_aade));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rchk(`REG_CONTROL, `CONTROL_RESET);
      rchk(`REG_DATA, `DATA_RESET);
      rchk(3'h7, 8'h00);
      $display("test reset done");
      wreg(`REG_INT_ENABLE, 8'h0f);
      wreg(`REG_CONTROL, 8'h20);
      rchk(`REG_CONTROL, 8'h20);
      wait_irq;
      rchk(`REG_CONTROL, 8'he1);
      wreg(`REG_INT_ENABLE, 8'h00);
      chk({7'h00, irq}, 8'h00);
      wreg(`REG_INT_CLEAR, 8'h0f);
      wreg(`REG_INT_ENABLE, 8'h0f);
      rchk(`REG_INT_STATUS, 8'h00);
      b = $urandom;
      sent_q.push_back(b);
      wreg(`REG_DATA, b);
      wreg(`REG_CONTROL, 8'h00);
      rchk(`REG_CONTROL, 8'hc0);
      wait_irq;
      rchk(`REG_CONTROL, 8'hc3);
      chk(i_far.rx, sent_q.pop_front());
      wreg(`REG_INT_CLEAR, 8'h0f);
      wreg(`REG_CONTROL, 8'h10);
      for (n = 0; n < 1000 && got !== 8'h40; n = n + 1) rreg(`REG_CONTROL);
      chk(got, 8'h40);
      $display("test master write done");
      // a far-side device holds sda low while the block sends ones
      wreg(`REG_CONTROL, 8'h20);
      wait_irq;
      jam <= 1'b1;
      wreg(`REG_INT_CLEAR, 8'h0f);
      wreg(`REG_DATA, 8'hff);
      wreg(`REG_CONTROL, 8'h00);
      wait_irq;
      rchk(`REG_CONTROL, 8'h05);
      wreg(`REG_CONTROL, 8'h00);
      rchk(`REG_CONTROL, 8'h00);
      jam <= 1'b0;
      // releasing sda makes a stop; let the two-flop sync see it first
      repeat (8) @(posedge clk);
      $display("test arbitration done");
      wreg(`REG_INT_CLEAR, 8'h0f);
      b = $urandom;
      i_far.send_byte(b);
      wait_irq;
      rchk(`REG_CONTROL, 8'h29);
      rchk(`REG_DATA, b);
      wreg(`REG_INT_CLEAR, 8'h0f);
      wreg(`REG_CONTROL, 8'h02);
      i_far.ack_stop;
      chk({7'h00, i_far.ack_seen}, 8'h00);
      wait_irq;
      rchk(`REG_CONTROL, 8'h13);
      wreg(`REG_CONTROL, 8'h00);
      rchk(`REG_CONTROL, 8'h00);
      $display("test slave receive done");
      finish_test;
   end
endmodule // smbus_control_flag_update_test
